// ### hdl/aas_edge_detect.sv
// synchroniser and edge detector for the external start pin
`timescale 1ns/1ns
`default_nettype none

module aas_edge_detect (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  import aas_pkg::*;

  aas_sync_t r;
  aas_sync_t next_r;

  // ==========================================================
  // two-flop synchroniser plus history stage
  always_comb begin
    next_r = r;
    next_r.s1 = i_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // one pulse per edge
  assign o_rise = r.s2 & ~r.s3;
  assign o_fall = ~r.s2 & r.s3;

endmodule : aas_edge_detect
`default_nettype wire

// ### hdl/aas_pkg.sv
// constants, field layouts and carrier types of the autoscan sequencer
package aas_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CH = 8;
  localparam int RES_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 6;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_PORT_LEVEL = 8'hc7;
  localparam logic [7:0] OFF_CTRL = 8'hd7;
  localparam logic [7:0] OFF_SCAN_MASK = 8'he7;
  localparam logic [7:0] OFF_RES_HI = 8'hc6;
  localparam logic [7:0] OFF_RES_LO_BASE = 8'hc8;
  localparam int RES_LO_IDX_W = 3;

  // ==========================================================
  // converter control register fields
  localparam int CTRL_PRESC_HI = 7;
  localparam int CTRL_PRESC_LO = 6;
  localparam int CTRL_RSVD = 5;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_START = 3;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_RISE = 1;
  localparam int CTRL_FALL = 0;

  // ==========================================================
  // reset values
  localparam logic [1:0] PRESC_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [5:0] HI_PAD = 6'h00;

  // ==========================================================
  // timing, in converter clock periods of m/2 machine cycles
  localparam logic [CNT_W-1:0] SAMPLE_PERIODS = 6'h02;
  localparam logic [CNT_W-1:0] BIT_PERIODS = 6'h0a;
  localparam logic [CNT_W-1:0] HALF_DIV_BASE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_TWO = 6'h02;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  // ==========================================================
  // types
  typedef logic [2:0] aas_chan_t;

  typedef enum logic [2:0] {
    AAS_IDLE,
    AAS_WAIT_TICK,
    AAS_CONV,
    AAS_STORE,
    AAS_INIT
  } aas_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } aas_bus_t;

  typedef struct packed {
    logic sampling;
    logic converting;
    logic store;
    aas_chan_t channel;
  } aas_core_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } aas_sync_t;

endpackage : aas_pkg

// ### hdl/aas_sequencer.sv
// autoscan converter control: registers, prescaler, scan sequencer, result store
//
// Functional notes
// - port level register reads pins, read-only
// - reset clears all registers except stored results
// - low power aborts, clears start, halts clock
// - done flag cleared only by software, reset
// - conversion lasts six m, then one store cycle
// - two sample, ten bit periods, store
// - channel spacing seven m cycles
// - start waits for divided clock phase
// - every run is autoscan, continuous or once
// - mask bit selects or skips channel
// - loop walks lowest to higher set bits
// - start by software or enabled pin edges
// - result stored per converted channel
// - loop end sets done flag
// - continuous mode keeps start, restarts loop
// - one-time mode stops and clears start
// - done flag holds off new starts
// - deferred start pending, reads zero
// - single mask bit ends after each conversion
// - results are unsigned ten-bit codes
// - prescaler divides by two four six eight
// - ignore starts while running, clear aborts
// - empty mask prevents any start
// - low byte read latches top two bits
`timescale 1ns/1ns
`default_nettype none

module aas_sequencer #(
  parameter int NUM_CH = aas_pkg::NUM_CH,
  parameter int RES_W = aas_pkg::RES_W
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire aas_pkg::aas_bus_t i_bus,
  input wire logic [7:0] i_port_pins,
  input wire logic i_external_start_pin,
  input wire logic i_low_power,
  input wire logic [RES_W-1:0] i_core_result,
  output logic [7:0] o_rdata,
  output aas_pkg::aas_core_t o_core,
  output logic o_start_status_flag,
  output logic o_scan_done_flag
);
  import aas_pkg::*;

  typedef struct packed {
    logic [1:0] prescale;
    logic cont;
    logic rise_en;
    logic fall_en;
    logic start;
    logic done;
    logic pend;
    logic [7:0] mask;
    logic [7:0] loop_mask;
    aas_chan_t chan;
    aas_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] div_cnt;
    logic [1:0] hi_latch;
    logic [7:0] rdata;
    aas_core_t core;
  } aas_regs_t;

  aas_regs_t r;
  aas_regs_t next_r;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic ext_rise;
  logic ext_fall;
  logic [RES_W-1:0] results [NUM_CH];

  // ==========================================================
  // reset release
  // asserts at once, releases two clocks later
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ==========================================================
  // external start pin
  aas_edge_detect u_edge (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_pin(i_external_start_pin),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  // ==========================================================
  // helpers
  function automatic logic [3:0] first_from(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i] && (i >= int'(from))) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : first_from

  // ==========================================================
  // next state
  always_comb begin
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] full;
    logic [CNT_W-1:0] conv_cycles;
    logic [CNT_W-1:0] bit_cycles;
    logic tick;
    logic req;
    logic sw_start;
    logic sw_abort;
    logic [3:0] nxt;
    logic [3:0] first;
    logic [RES_LO_IDX_W-1:0] idx;
    half = '0;
    full = '0;
    conv_cycles = '0;
    bit_cycles = '0;
    tick = 1'b0;
    req = 1'b0;
    sw_start = 1'b0;
    sw_abort = 1'b0;
    nxt = '0;
    first = '0;
    idx = '0;
    next_r = r;

    half = CNT_W'({4'h0, r.prescale} + HALF_DIV_BASE);
    full = CNT_W'(half << 1);
    conv_cycles = CNT_W'(half * (SAMPLE_PERIODS + BIT_PERIODS));
    // sample phase then ten bit periods
    bit_cycles = CNT_W'(half * BIT_PERIODS);
    tick = (r.div_cnt == CNT_ZERO);

    // divided clock halts in low power
    if (i_low_power) begin
      next_r.div_cnt = CNT_ZERO;
    end else if (tick) begin
      next_r.div_cnt = CNT_W'(half - CNT_ONE);
    end else begin
      next_r.div_cnt = CNT_W'(r.div_cnt - CNT_ONE);
    end

    // ==========================================================
    // register reads
    next_r.rdata = READ_ZERO;
    if (i_bus.rd) begin
      if (i_bus.addr == OFF_PORT_LEVEL) begin
        next_r.rdata = i_port_pins;
      end else if (i_bus.addr == OFF_CTRL) begin
        next_r.rdata[CTRL_PRESC_HI] = r.prescale[1];
        next_r.rdata[CTRL_PRESC_LO] = r.prescale[0];
        next_r.rdata[CTRL_RSVD] = 1'b0;
        next_r.rdata[CTRL_DONE] = r.done;
        next_r.rdata[CTRL_START] = r.start;
        next_r.rdata[CTRL_CONT] = r.cont;
        next_r.rdata[CTRL_RISE] = r.rise_en;
        next_r.rdata[CTRL_FALL] = r.fall_en;
      end else if (i_bus.addr == OFF_SCAN_MASK) begin
        next_r.rdata = r.mask;
      end else if (i_bus.addr == OFF_RES_HI) begin
        next_r.rdata = {HI_PAD, r.hi_latch};
      end else if (i_bus.addr[7:RES_LO_IDX_W] == OFF_RES_LO_BASE[7:RES_LO_IDX_W]) begin
        idx = i_bus.addr[RES_LO_IDX_W-1:0];
        next_r.rdata = results[idx][7:0];
        // latch top bits on low read
        next_r.hi_latch = results[idx][RES_W-1:8];
      end
    end

    // ==========================================================
    // register writes
    if (i_bus.wr) begin
      if (i_bus.addr == OFF_CTRL) begin
        next_r.prescale = {i_bus.wdata[CTRL_PRESC_HI], i_bus.wdata[CTRL_PRESC_LO]};
        next_r.cont = i_bus.wdata[CTRL_CONT];
        next_r.rise_en = i_bus.wdata[CTRL_RISE];
        next_r.fall_en = i_bus.wdata[CTRL_FALL];
        next_r.done = r.done & i_bus.wdata[CTRL_DONE];
        if (i_bus.wdata[CTRL_START]) begin
          sw_start = 1'b1;
        end else begin
          sw_abort = r.start;
        end
      end else if (i_bus.addr == OFF_SCAN_MASK) begin
        next_r.mask = i_bus.wdata;
      end
    end

    req = sw_start | (ext_rise & r.rise_en) | (ext_fall & r.fall_en);

    // ==========================================================
    // scan sequencer
    unique case (r.state)
      AAS_IDLE: begin
      end
      AAS_WAIT_TICK: begin
        if (tick) begin
          next_r.state = AAS_CONV;
          next_r.cnt = CNT_W'(conv_cycles - CNT_ONE);
        end
      end
      AAS_CONV: begin
        if (r.cnt == CNT_ZERO) begin
          next_r.state = AAS_STORE;
        end else begin
          next_r.cnt = CNT_W'(r.cnt - CNT_ONE);
        end
      end
      AAS_STORE: begin
        nxt = first_from(r.loop_mask, 4'({1'b0, r.chan} + 4'h1));
        first = first_from(r.mask, 4'h0);
        // init period fills to seven m
        next_r.cnt = CNT_W'(full - CNT_TWO);
        if (nxt[3]) begin
          next_r.chan = nxt[2:0];
          next_r.state = AAS_INIT;
        end else begin
          next_r.done = 1'b1;
          if (r.cont && first[3]) begin
            next_r.loop_mask = r.mask;
            next_r.chan = first[2:0];
            next_r.state = AAS_INIT;
          end else begin
            next_r.start = 1'b0;
            next_r.state = AAS_IDLE;
          end
        end
      end
      AAS_INIT: begin
        if (r.cnt == CNT_ZERO) begin
          next_r.state = AAS_CONV;
          next_r.cnt = CNT_W'(conv_cycles - CNT_ONE);
        end else begin
          next_r.cnt = CNT_W'(r.cnt - CNT_ONE);
        end
      end
      default: begin
        // illegal code falls back to idle
        next_r.state = AAS_IDLE;
      end
    endcase

    // ==========================================================
    // start handling
    // hold start while done set
    if (req && r.done && !r.start) begin
      next_r.pend = 1'b1;
    end
    if (!r.start && !r.done && (req || r.pend) && !i_low_power) begin
      first = first_from(r.mask, 4'h0);
      next_r.pend = 1'b0;
      if (first[3]) begin
        next_r.start = 1'b1;
        next_r.loop_mask = r.mask;
        next_r.chan = first[2:0];
        next_r.state = AAS_WAIT_TICK;
      end
    end

    // ==========================================================
    // abort
    if (sw_abort || i_low_power) begin
      next_r.start = 1'b0;
      next_r.state = AAS_IDLE;
      next_r.cnt = CNT_ZERO;
      if (i_low_power) begin
        next_r.pend = 1'b0;
      end
    end

    // ==========================================================
    // analog core controls
    next_r.core.converting = (next_r.state == AAS_CONV);
    next_r.core.sampling = (next_r.state == AAS_CONV) && (next_r.cnt >= bit_cycles);
    next_r.core.store = (next_r.state == AAS_STORE);
    next_r.core.channel = next_r.chan;
  end

  // ==========================================================
  // state register
  // reset clears control and mask
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.prescale <= PRESC_RESET;
      r.mask <= MASK_RESET;
      r.state <= AAS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // result store, no reset
  // write result of converted channel
  always_ff @(posedge i_mclk) begin
    if (r.state == AAS_STORE) begin
      results[r.chan] <= i_core_result;
    end
  end

  // ==========================================================
  // outputs
  // every output taken straight from the state register
  assign o_rdata = r.rdata;
  assign o_core = r.core;
  assign o_start_status_flag = r.start;
  assign o_scan_done_flag = r.done;

endmodule : aas_sequencer
`default_nettype wire

// ### verification/aas_core_model.sv
// behavioural model of the analog converter core
`timescale 1ns/1ns
`default_nettype none
module aas_core_model (
  input wire logic i_mclk,
  input wire aas_pkg::aas_core_t i_core,
  input wire logic [79:0] i_codes,
  output logic [9:0] o_result
);
  import aas_pkg::*;
  logic [9:0] last = 10'h3a5;
  // ==========================================================
  // unsigned result codes
  // valid only in the store cycle, else a changing pattern
  always_comb o_result = i_core.store ? i_codes[i_core.channel * 10 +: 10] : ~last;
  always @(posedge i_mclk) last <= o_result;
endmodule : aas_core_model
`default_nettype wire

// ### verification/aas_seq_asserts.sv
// port assertions for the autoscan sequencer
`timescale 1ns/1ns
`default_nettype none
module aas_seq_asserts #(
  parameter int RES_W = aas_pkg::RES_W
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire aas_pkg::aas_bus_t i_bus,
  input wire logic [7:0] i_port_pins,
  input wire logic i_external_start_pin,
  input wire logic i_low_power,
  input wire logic [RES_W-1:0] i_core_result,
  input wire logic [7:0] o_rdata,
  input wire aas_pkg::aas_core_t o_core,
  input wire logic o_start_status_flag,
  input wire logic o_scan_done_flag
);
  import aas_pkg::*;
  // ==========================================================
  // helper: divisor tracked from control writes, conversion length
  logic [3:0] m;
  logic [5:0] conv_cnt;
  logic ctrl_wr;
  assign ctrl_wr = i_bus.wr && i_bus.addr == OFF_CTRL;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      m <= 4'h2;
      conv_cnt <= 6'h00;
    end else begin
      if (ctrl_wr) m <= 4'({i_bus.wdata[7:6], 1'b0}) + 4'h2;
      conv_cnt <= o_core.converting ? conv_cnt + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // assertions
  a_port_read:
    assert property (i_bus.rd && i_bus.addr == OFF_PORT_LEVEL |=> o_rdata == $past(i_port_pins))
    else $error("port level read wrong");
  a_done_hold:
    assert property (o_scan_done_flag && !(ctrl_wr && !i_bus.wdata[CTRL_DONE]) |=> o_scan_done_flag)
    else $error("done flag lost");
  a_done_cause:
    assert property ($rose(o_scan_done_flag) |-> $past(o_core.store))
    else $error("done flag without store");
  a_lp_abort:
    assert property (i_low_power |=> !o_start_status_flag && !o_core.converting)
    else $error("low power did not abort");
  a_lp_no_done:
    assert property (i_low_power && !o_core.store && !o_scan_done_flag |=> !o_scan_done_flag)
    else $error("low power set done flag");
  a_store_once:
    assert property (o_core.store |=> !o_core.store && !o_core.sampling)
    else $error("store not a single cycle");
  a_conv_len:
    assert property (o_core.store |-> conv_cnt == 6'(6 * m))
    else $error("conversion length wrong");
  a_sample_len:
    assert property ($fell(o_core.sampling) && o_core.converting |-> conv_cnt == 6'(m))
    else $error("sample period wrong");
  a_start_gate:
    assert property ($rose(o_start_status_flag) |-> !o_scan_done_flag)
    else $error("start while done set");
  a_start_delay:
    assert property ($rose(o_start_status_flag) |-> ##[1:4] o_core.sampling)
    else $error("first sample too late");
  c_store: cover property (o_core.store);
  c_done: cover property ($rose(o_scan_done_flag));
  c_cont: cover property (o_scan_done_flag && o_start_status_flag);
endmodule : aas_seq_asserts
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the autoscan sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import aas_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  aas_bus_t bus = '0;
  logic [7:0] pins = 8'h00;
  logic xpin = 1'b0;
  logic lp = 1'b0;
  logic [79:0] codes = '0;
  logic [9:0] result;
  logic [7:0] rdata;
  aas_core_t core;
  logic start_f;
  logic done_f;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int m = 2;
  int last = 0;
  logic [7:0] seed = 8'h1c;
  logic [7:0] mask = 8'h00;
  logic [7:0] ctl;
  logic [7:0] d;
  logic [9:0] exp_res [8];
  int exp_q [$];

  always #5 i_mclk = ~i_mclk;

  aas_sequencer aas_sequencer_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_bus(bus),
    .i_port_pins(pins), .i_external_start_pin(xpin), .i_low_power(lp),
    .i_core_result(result), .o_rdata(rdata), .o_core(core),
    .o_start_status_flag(start_f), .o_scan_done_flag(done_f));
  aas_core_model aas_core_model_i (.i_mclk(i_mclk), .i_core(core), .i_codes(codes),
    .o_result(result));

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge i_mclk);
    bus.addr <= a;
    bus.wdata <= dv;
    bus.wr <= 1'b1;
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_done();
    int n;
    n = 0;
    while (done_f !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk(16'(done_f), 16'h0001);
  endtask : wait_done

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // reference model: channel order, spacing, stored codes
  always @(posedge i_mclk) begin
    cyc++;
    if (core.store === 1'b1) begin
      if (exp_q.size() == 0) begin
        for (int c = 0; c < 8; c++) if (mask[c]) exp_q.push_back(c);
        last = 0;
      end
      chk(16'(core.channel), 16'(exp_q.pop_front()));
      if (last != 0) chk(16'(cyc - last), 16'(7 * m));
      last = exp_q.size() != 0 ? cyc : 0;
      exp_res[core.channel] = codes[core.channel * 10 +: 10];
    end
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd(OFF_CTRL); chk(16'(d), 16'h0000);
    rd(OFF_SCAN_MASK); chk(16'(d), 16'(MASK_RESET));
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 10; i++) begin
        seed = lfsr(seed);
        codes[i * 8 +: 8] = seed;
      end
      pins <= seed;
      mask = (p == 3) ? 8'h80 : seed;
      ctl = {2'(p), 6'h00};
      m = 2 * p + 2;
      wr(OFF_SCAN_MASK, mask);
      wr(OFF_CTRL, ctl | 8'h08);
      rd(OFF_PORT_LEVEL); chk(16'(d), 16'(pins));
      wait_done();
      rd(OFF_CTRL); chk(16'(d), 16'(ctl | 8'h10));
      for (int c = 0; c < 8; c++) if (mask[c]) begin
        rd(OFF_RES_LO_BASE + 8'(c)); chk(16'(d), 16'(exp_res[c][7:0]));
        rd(OFF_RES_HI); chk(16'(d), 16'(exp_res[c][9:8]));
      end
      wr(OFF_CTRL, ctl | 8'h18);
      rd(OFF_CTRL); chk(16'(d), 16'(ctl | 8'h10));
      wr(OFF_CTRL, ctl);
      rd(OFF_CTRL); chk(16'(d[3]), 16'h0001);
      wait_done();
      wr(OFF_CTRL, ctl);
    end
    // continuous loop then software abort
    m = 2;
    mask = 8'h41;
    wr(OFF_SCAN_MASK, mask);
    wr(OFF_CTRL, 8'h0c);
    wait_done();
    rd(OFF_CTRL); chk(16'(d), 16'h001c);
    repeat (30) @(posedge i_mclk);
    wr(OFF_CTRL, 8'h14);
    repeat (2) @(posedge i_mclk);
    #1 chk(16'({start_f, core.converting}), 16'h0000);
    wr(OFF_CTRL, 8'h00);
    exp_q = {};
    // external start edges, each direction enabled alone
    mask = 8'h02;
    wr(OFF_SCAN_MASK, mask);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CTRL, k < 2 ? 8'h02 : 8'h01);
      xpin <= ~xpin;
      repeat (8) @(posedge i_mclk);
      #1 chk(16'(start_f), 16'(xpin == (k < 2)));
      if (start_f) wait_done();
    end
    // low power abort keeps results
    mask = 8'hff;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_SCAN_MASK, mask);
    wr(OFF_CTRL, 8'h08);
    repeat (20) @(posedge i_mclk);
    lp <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 chk(16'({start_f, done_f, core.converting}), 16'h0000);
    rd(OFF_RES_LO_BASE + 8'h07); chk(16'(d), 16'(exp_res[7][7:0]));
    @(posedge i_mclk);
    lp <= 1'b0;
    exp_q = {};
    // empty mask never starts
    wr(OFF_SCAN_MASK, 8'h00);
    wr(OFF_CTRL, 8'h08);
    rd(OFF_CTRL); chk(16'(d), 16'h0000);
    wrap_up();
  end
endmodule : testbench

bind aas_sequencer aas_seq_asserts #(.RES_W(RES_W)) aas_seq_asserts_i (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_bus(i_bus), .i_port_pins(i_port_pins),
  .i_external_start_pin(i_external_start_pin), .i_low_power(i_low_power),
  .i_core_result(i_core_result), .o_rdata(o_rdata), .o_core(o_core),
  .o_start_status_flag(o_start_status_flag), .o_scan_done_flag(o_scan_done_flag));
`default_nettype wire
